// file: design/omcd_module.sv
// Optical module end: laser fault latch, light-loss flag and two-wire memory slave
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module omcd_module #(
   parameter logic [15:0] DARK_LEVEL = omcd_pkg::DARK_LEVEL
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   omcd_link_if.dev lnk,
   input wire logic op_cond_bad,
   input wire logic eye_trip,
   input wire logic [15:0] temp,
   input wire logic [15:0] vcc,
   input wire logic [15:0] bias,
   input wire logic [15:0] tx_pwr,
   input wire logic [15:0] rx_pwr,
   output logic laser_en
);
   typedef struct packed {
      logic [255:0][7:0] mem;
      omcd_pkg::omcd_dst_t st;
      logic [7:0] sh;
      logic [3:0] cnt;
      logic [7:0] ptr;
      logic diag;
      logic rw;
      logic first;
      logic nack;
      logic scl_q;
      logic sda_q;
      logic off_q;
      logic fault;
      logic dark;
      logic laser_en;
      logic sda_oe;
   } omcd_dev_t;

   omcd_dev_t s, s_nxt;
   logic scl_s;
   logic sda_s;
   logic off_s;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   logic load;
   logic [7:0] rdb;
   logic [7:0] dix;
   logic [0:2*omcd_pkg::DIAG_WORDS-1][7:0] mon;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   omcd_sync #(
      .W(3),
      .INIT(3'h7)
   ) omcd_sync_inst (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .d({lnk.scl, lnk.sda, lnk.tx_off}),
      .q({scl_s, sda_s, off_s})
   );

   // Calibrated readings, most significant byte first
   assign mon = {temp, vcc, bias, tx_pwr, rx_pwr};

   assign scl_rise = scl_s & ~s.scl_q;
   assign scl_fall = ~scl_s & s.scl_q;
   assign start = scl_s & s.scl_q & s.sda_q & ~sda_s;
   assign stop = scl_s & s.scl_q & ~s.sda_q & sda_s;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_nxt = s;
      load = 1'b0;
      s_nxt.scl_q = scl_s;
      s_nxt.sda_q = sda_s;
      s_nxt.off_q = off_s;

      // Laser control
      if (off_s && !s.off_q) begin
         s_nxt.fault = 1'b0;
      end
      if ((op_cond_bad || eye_trip) && !off_s) begin
         s_nxt.fault = 1'b1;
      end
      s_nxt.laser_en = !off_s && !s_nxt.fault;
      s_nxt.dark = rx_pwr < DARK_LEVEL;

      // Byte source for reads
      dix = 8'(s.ptr - omcd_pkg::DIAG_BASE);
      rdb = s.mem[s.ptr];
      if (s.diag) begin
         rdb = 8'h00;
         if (dix < omcd_pkg::DIAG_BYTES) begin
            rdb = mon[dix[3:0]];
         end
      end

      // Two-wire slave
      if (stop) begin
         s_nxt.st = omcd_pkg::OMCD_D_IDLE;
         s_nxt.sda_oe = 1'b0;
      end else if (start) begin
         s_nxt.st = omcd_pkg::OMCD_D_ADDR;
         s_nxt.cnt = 4'h0;
         s_nxt.first = 1'b1;
         s_nxt.sda_oe = 1'b0;
      end else begin
         unique case (s.st)
            omcd_pkg::OMCD_D_IDLE: begin
               s_nxt.sda_oe = 1'b0;
            end
            omcd_pkg::OMCD_D_ADDR: begin
               if (scl_rise) begin
                  s_nxt.sh = {s.sh[6:0], sda_s};
                  s_nxt.cnt = 4'(s.cnt + 4'h1);
               end else if (scl_fall && s.cnt == omcd_pkg::BYTE_BITS) begin
                  if (s.sh[7:1] == omcd_pkg::ID_SPACE[7:1] || s.sh[7:1] == omcd_pkg::DIAG_SPACE[7:1]) begin
                     s_nxt.diag = s.sh[1];
                     s_nxt.rw = s.sh[0];
                     s_nxt.sda_oe = 1'b1;
                     s_nxt.st = omcd_pkg::OMCD_D_ACK;
                  end else begin
                     s_nxt.st = omcd_pkg::OMCD_D_IDLE;
                  end
               end
            end
            omcd_pkg::OMCD_D_ACK: begin
               if (scl_fall) begin
                  s_nxt.cnt = 4'h0;
                  if (s.rw) begin
                     load = 1'b1;
                  end else begin
                     s_nxt.sda_oe = 1'b0;
                     s_nxt.st = omcd_pkg::OMCD_D_WR;
                  end
               end
            end
            omcd_pkg::OMCD_D_WR: begin
               if (scl_rise) begin
                  s_nxt.sh = {s.sh[6:0], sda_s};
                  s_nxt.cnt = 4'(s.cnt + 4'h1);
               end else if (scl_fall && s.cnt == omcd_pkg::BYTE_BITS) begin
                  if (s.first) begin
                     s_nxt.ptr = s.sh;
                     s_nxt.first = 1'b0;
                  end else begin
                     if (!s.diag) begin
                        s_nxt.mem[s.ptr] = s.sh;
                     end
                     s_nxt.ptr = 8'(s.ptr + 8'h01);
                  end
                  s_nxt.sda_oe = 1'b1;
                  s_nxt.st = omcd_pkg::OMCD_D_ACK;
               end
            end
            omcd_pkg::OMCD_D_RD: begin
               if (scl_fall) begin
                  if (s.cnt == 4'(omcd_pkg::BYTE_BITS - 4'h1)) begin
                     s_nxt.sda_oe = 1'b0;
                     s_nxt.st = omcd_pkg::OMCD_D_RACK;
                  end else begin
                     s_nxt.sh = {s.sh[6:0], 1'b0};
                     s_nxt.sda_oe = ~s.sh[6];
                     s_nxt.cnt = 4'(s.cnt + 4'h1);
                  end
               end
            end
            omcd_pkg::OMCD_D_RACK: begin
               if (scl_rise) begin
                  s_nxt.nack = sda_s;
               end else if (scl_fall) begin
                  s_nxt.cnt = 4'h0;
                  if (s.nack) begin
                     s_nxt.st = omcd_pkg::OMCD_D_IDLE;
                  end else begin
                     load = 1'b1;
                  end
               end
            end
            default: begin
               s_nxt.st = omcd_pkg::OMCD_D_IDLE;
               s_nxt.sda_oe = 1'b0;
            end
         endcase
      end

      // Present next byte, first bit on the line
      if (load) begin
         s_nxt.sh = rdb;
         s_nxt.ptr = 8'(s.ptr + 8'h01);
         s_nxt.sda_oe = ~rdb[7];
         s_nxt.st = omcd_pkg::OMCD_D_RD;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
         s.scl_q <= 1'b1;
         s.sda_q <= 1'b1;
         s.off_q <= 1'b1;
         s.dark <= 1'b1;
      end else begin
         s <= s_nxt;
      end
   end

   // ----------------------------------------
   // Pin drivers, open drain pulls low
   // ----------------------------------------
   assign lnk.fault_o = 1'b0;
   assign lnk.fault_oe = ~s.fault;
   assign lnk.absent_o = 1'b0;
   assign lnk.absent_oe = ~s.dark;
   assign lnk.present_o = 1'b0;
   assign lnk.present_oe = 1'b1;
   assign lnk.sda_d_o = 1'b0;
   assign lnk.sda_d_oe = s.sda_oe;
   assign laser_en = s.laser_en;
endmodule

// file: common/omcd_pkg.sv
// Shared constants and types for the optical module control and diagnostic link
package omcd_pkg;
   // ----------------------------------------
   // Two-wire memory spaces
   // ----------------------------------------
   localparam logic [7:0] ID_SPACE = 8'ha0;
   localparam logic [7:0] DIAG_SPACE = 8'ha2;
   localparam logic [7:0] DIAG_BASE = 8'h60;
   localparam int DIAG_WORDS = 5;
   localparam logic [7:0] DIAG_BYTES = 8'h0a;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [15:0] DARK_LEVEL = 16'h0010;
   // ----------------------------------------
   // Host register map
   // ----------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CMD = 8'h04;
   localparam logic [7:0] REG_STAT = 8'h08;
   localparam logic [7:0] REG_EVT = 8'h0c;
   localparam logic [7:0] REG_EVT_CLR = 8'h10;
   localparam logic [7:0] REG_EVT_EN = 8'h14;
   localparam logic [1:0] CTRL_RST = 2'h1;
   localparam int CTRL_OFF_BIT = 0;
   localparam int CTRL_FLOAT_BIT = 1;
   localparam int CMD_SPACE_BIT = 8;
   localparam int CMD_WR_BIT = 9;
   localparam int CMD_DATA_LSB = 16;
   localparam int EVT_W = 3;
   localparam int EVT_DONE = 0;
   localparam int EVT_FAULT = 1;
   localparam int EVT_DARK = 2;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int SYS_PERIOD_NS = 100;
   localparam int LINK_PERIOD_NS = 800;
   localparam int QTR_CYC = LINK_PERIOD_NS / (4 * SYS_PERIOD_NS);
   // ----------------------------------------
   // State machines
   // ----------------------------------------
   typedef enum logic [2:0] {
      OMCD_D_IDLE = 3'h0,
      OMCD_D_ADDR = 3'h1,
      OMCD_D_ACK = 3'h2,
      OMCD_D_WR = 3'h3,
      OMCD_D_RD = 3'h4,
      OMCD_D_RACK = 3'h5
   } omcd_dst_t;
   typedef enum logic [1:0] {
      OMCD_H_IDLE = 2'h0,
      OMCD_H_START = 2'h1,
      OMCD_H_BIT = 2'h2,
      OMCD_H_STOP = 2'h3
   } omcd_hst_t;
endpackage

// file: common/omcd_link_if.sv
// Module pins between host board and optical module, with pull-up resolution
`timescale 1ns/1ps
interface omcd_link_if;
   logic tx_off_o;
   logic tx_off_oe;
   logic tx_off;
   logic fault_o;
   logic fault_oe;
   logic fault;
   logic absent_o;
   logic absent_oe;
   logic rx_light_absent;
   logic present_o;
   logic present_oe;
   logic present;
   logic scl_o;
   logic scl_oe;
   logic scl;
   logic sda_h_o;
   logic sda_h_oe;
   logic sda_d_o;
   logic sda_d_oe;
   logic sda;
   // Undriven pins read high through their pull-ups
   assign tx_off = tx_off_oe ? tx_off_o : 1'b1;
   assign fault = fault_oe ? fault_o : 1'b1;
   assign rx_light_absent = absent_oe ? absent_o : 1'b1;
   assign present = present_oe ? present_o : 1'b1;
   assign scl = scl_oe ? scl_o : 1'b1;
   assign sda = (sda_h_oe ? sda_h_o : 1'b1) & (sda_d_oe ? sda_d_o : 1'b1);
   modport dev (
      input tx_off,
      input scl,
      input sda,
      output fault_o,
      output fault_oe,
      output absent_o,
      output absent_oe,
      output present_o,
      output present_oe,
      output sda_d_o,
      output sda_d_oe
   );
   modport host (
      input fault,
      input rx_light_absent,
      input present,
      input sda,
      output tx_off_o,
      output tx_off_oe,
      output scl_o,
      output scl_oe,
      output sda_h_o,
      output sda_h_oe
   );
endinterface

// file: design/omcd_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module omcd_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '1
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] q;
   } omcd_sync_t;
   omcd_sync_t s, s_nxt;
   always_comb begin
      s_nxt.meta = d;
      s_nxt.q = s.meta;
   end
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= {INIT, INIT};
      end else begin
         s <= s_nxt;
      end
   end
   assign q = s.q;
endmodule

// file: design/omcd_host.sv
// Host end: shut-off control, pin monitor with events, two-wire memory master
`timescale 1ns/1ps
module omcd_host #(
   parameter int QTR_CYC = omcd_pkg::QTR_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   omcd_link_if.host lnk,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic irq
);
   typedef struct packed {
      logic [1:0] ctrl;
      logic [7:0] ptr;
      logic diag;
      logic wrt;
      logic [7:0] data;
      omcd_pkg::omcd_hst_t st;
      logic [1:0] q;
      logic [7:0] tcnt;
      logic [3:0] b;
      logic [1:0] step;
      logic [7:0] tx;
      logic [7:0] rx;
      logic nack;
      logic busy;
      logic [omcd_pkg::EVT_W-1:0] evt;
      logic [omcd_pkg::EVT_W-1:0] en;
      logic [31:0] rdata;
      logic scl_oe;
      logic sda_oe;
      logic fault_q;
      logic dark_q;
   } omcd_host_t;

   omcd_host_t s, s_nxt;
   logic sda_s;
   logic fault_s;
   logic dark_s;
   logic present_s;
   logic tick;
   logic [omcd_pkg::EVT_W-1:0] ev;
   logic [omcd_pkg::EVT_W-1:0] clr;
   logic [7:0] sp;

   omcd_sync #(
      .W(4),
      .INIT(4'hf)
   ) omcd_sync_inst (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .d({lnk.sda, lnk.fault, lnk.rx_light_absent, lnk.present}),
      .q({sda_s, fault_s, dark_s, present_s})
   );

   assign tick = s.busy && s.tcnt == 8'(QTR_CYC - 1);
   assign sp = s.diag ? omcd_pkg::DIAG_SPACE : omcd_pkg::ID_SPACE;

   always_comb begin
      s_nxt = s;
      ev = '0;
      clr = '0;
      s_nxt.rdata = 32'h0000_0000;
      s_nxt.fault_q = fault_s;
      s_nxt.dark_q = dark_s;
      // ----------------------------------------
      // Register port
      // ----------------------------------------
      if (rd) begin
         unique case (addr)
            omcd_pkg::REG_CTRL: s_nxt.rdata = {30'h0, s.ctrl};
            omcd_pkg::REG_STAT: s_nxt.rdata = {16'h0, s.rx, 3'h0, present_s, dark_s, fault_s, s.nack, s.busy};
            omcd_pkg::REG_EVT: s_nxt.rdata = {29'h0, s.evt};
            omcd_pkg::REG_EVT_EN: s_nxt.rdata = {29'h0, s.en};
            default: s_nxt.rdata = 32'h0000_0000;
         endcase
      end
      if (wr) begin
         unique case (addr)
            omcd_pkg::REG_CTRL: s_nxt.ctrl = wdata[1:0];
            omcd_pkg::REG_EVT_EN: s_nxt.en = wdata[omcd_pkg::EVT_W-1:0];
            omcd_pkg::REG_EVT_CLR: clr = wdata[omcd_pkg::EVT_W-1:0];
            omcd_pkg::REG_CMD: begin
               if (!s.busy) begin
                  s_nxt.ptr = wdata[7:0];
                  s_nxt.diag = wdata[omcd_pkg::CMD_SPACE_BIT];
                  s_nxt.wrt = wdata[omcd_pkg::CMD_WR_BIT];
                  s_nxt.data = wdata[omcd_pkg::CMD_DATA_LSB+:8];
                  s_nxt.busy = 1'b1;
                  s_nxt.nack = 1'b0;
                  s_nxt.st = omcd_pkg::OMCD_H_START;
                  s_nxt.q = 2'h0;
                  s_nxt.tcnt = 8'h00;
                  s_nxt.step = 2'h0;
               end
            end
            default: begin
            end
         endcase
      end
      // ----------------------------------------
      // Two-wire master, four quarters per bit
      // ----------------------------------------
      if (s.busy) begin
         s_nxt.tcnt = tick ? 8'h00 : 8'(s.tcnt + 8'h01);
      end
      if (tick) begin
         s_nxt.q = 2'(s.q + 2'h1);
         unique case (s.st)
            omcd_pkg::OMCD_H_IDLE: begin
            end
            omcd_pkg::OMCD_H_START: begin
               unique case (s.q)
                  2'h0: s_nxt.sda_oe = 1'b0;
                  2'h1: s_nxt.scl_oe = 1'b0;
                  2'h2: s_nxt.sda_oe = 1'b1;
                  2'h3: begin
                     s_nxt.scl_oe = 1'b1;
                     s_nxt.st = omcd_pkg::OMCD_H_BIT;
                     s_nxt.b = 4'h0;
                     s_nxt.tx = s.step == 2'h0 ? sp : (sp | 8'h01);
                  end
               endcase
            end
            omcd_pkg::OMCD_H_BIT: begin
               unique case (s.q)
                  2'h0: s_nxt.sda_oe = s.b < omcd_pkg::BYTE_BITS && s.step != 2'h3 && !s.tx[7];
                  2'h1: s_nxt.scl_oe = 1'b0;
                  2'h2: begin
                     if (s.b < omcd_pkg::BYTE_BITS) begin
                        s_nxt.rx = {s.rx[6:0], sda_s};
                     end else if (s.step != 2'h3) begin
                        s_nxt.nack = sda_s;
                     end
                  end
                  2'h3: begin
                     s_nxt.scl_oe = 1'b1;
                     if (s.b < omcd_pkg::BYTE_BITS) begin
                        s_nxt.b = 4'(s.b + 4'h1);
                        s_nxt.tx = {s.tx[6:0], 1'b0};
                     end else begin
                        s_nxt.step = 2'(s.step + 2'h1);
                        s_nxt.b = 4'h0;
                        if (s.nack || (s.wrt && s.step == 2'h2) || s.step == 2'h3) begin
                           s_nxt.st = omcd_pkg::OMCD_H_STOP;
                        end else if (!s.wrt && s.step == 2'h1) begin
                           s_nxt.st = omcd_pkg::OMCD_H_START;
                        end else begin
                           s_nxt.tx = s.step == 2'h0 ? s.ptr : s.data;
                        end
                     end
                  end
               endcase
            end
            omcd_pkg::OMCD_H_STOP: begin
               unique case (s.q)
                  2'h0: s_nxt.sda_oe = 1'b1;
                  2'h1: s_nxt.scl_oe = 1'b0;
                  2'h2: s_nxt.sda_oe = 1'b0;
                  2'h3: begin
                     s_nxt.st = omcd_pkg::OMCD_H_IDLE;
                     s_nxt.busy = 1'b0;
                     ev[omcd_pkg::EVT_DONE] = 1'b1;
                  end
               endcase
            end
         endcase
      end
      // Sticky events, a new event beats a clear
      ev[omcd_pkg::EVT_FAULT] = fault_s & ~s.fault_q;
      ev[omcd_pkg::EVT_DARK] = dark_s ^ s.dark_q;
      s_nxt.evt = (s.evt & ~clr) | ev;
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
         s.ctrl <= omcd_pkg::CTRL_RST;
         s.fault_q <= 1'b1;
         s.dark_q <= 1'b1;
      end else begin
         s <= s_nxt;
      end
   end

   // Shut-off cycling through the control register clears module faults
   assign lnk.tx_off_o = s.ctrl[omcd_pkg::CTRL_OFF_BIT];
   assign lnk.tx_off_oe = ~s.ctrl[omcd_pkg::CTRL_FLOAT_BIT];
   assign lnk.scl_o = 1'b0;
   assign lnk.scl_oe = s.scl_oe;
   assign lnk.sda_h_o = 1'b0;
   assign lnk.sda_h_oe = s.sda_oe;
   assign rdata = s.rdata;
   assign irq = |(s.evt & s.en);
endmodule

// file: test/omcd_chk.sv
// Pin-level checks between the host end and the module end
`timescale 1ns/1ps
module omcd_chk (
   input logic sys_clk,
   input logic rst_b,
   input logic tx_off,
   input logic fault,
   input logic present,
   input logic scl,
   input logic sda,
   input logic sda_h_oe,
   input logic sda_d_oe,
   input logic rx_light_absent
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   AST_PRESENT_LOW: assert property (!present)
      else $error("presence pin not low");
   AST_OFF_NO_FAULT: assert property (tx_off [*6] |=> !$rose(fault))
      else $error("fault rose while shut-off high");
   AST_CYCLE_CLEARS: assert property ($rose(tx_off) ##0 tx_off [*5] |-> !fault)
      else $error("fault not cleared by shut-off cycle");
   AST_FALL_NEEDS_OFF: assert property ($fell(fault) |-> $past(tx_off, 2) || $past(tx_off, 3) || $past(tx_off, 4))
      else $error("fault fell without shut-off");
   AST_SCL_LOW_TIME: assert property ($fell(scl) |=> (!scl) [*3] ##1 scl)
      else $error("serial clock low phase wrong");
   AST_DEV_HOLD_HIGH: assert property (scl && $past(scl) |-> $stable(sda_d_oe))
      else $error("module changed data with clock high");
   AST_NO_CLASH: assert property (sda_d_oe && sda_h_oe |-> !scl)
      else $error("both ends drive data with clock high");
   AST_INIT_OFF: assert property ($rose(rst_b) |-> tx_off)
      else $error("shut-off not high at start");
   // ----------------------------------------
   // Coverage
   // ----------------------------------------
   CV_FAULT_SET: cover property ($rose(fault));
   CV_FAULT_CLR: cover property ($fell(fault));
   CV_START: cover property (scl && $fell(sda));
   CV_DARK: cover property ($rose(rx_light_absent));
endmodule

// file: test/optical_module_ctrl_diag_tb.sv
// Self-checking bench joining host end and module end over the pin interface
`timescale 1ns/1ps
module optical_module_ctrl_diag_tb;
   typedef struct {string nm; logic [31:0] e; logic [31:0] m; logic [1:0] sel;} omcd_note_t;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_d = 1'b0;
   logic pk = 1'b0;
   logic op_cond_bad = 1'b0;
   logic eye_trip = 1'b0;
   logic [15:0] temp, vcc, bias, tx_pwr, rx_pwr;
   logic [31:0] rdata, got;
   logic irq, laser_en;
   int errors = 0;
   int compares = 0;
   int seed = 82963;
   int cyc = 0;
   omcd_note_t notes[$];
   omcd_link_if lnk();
   omcd_module omcd_module_inst (.sys_clk(sys_clk), .rst_b(rst_b), .lnk(lnk.dev), .op_cond_bad(op_cond_bad),
      .eye_trip(eye_trip), .temp(temp), .vcc(vcc), .bias(bias), .tx_pwr(tx_pwr), .rx_pwr(rx_pwr),
      .laser_en(laser_en));
   omcd_host omcd_host_inst (.sys_clk(sys_clk), .rst_b(rst_b), .lnk(lnk.host), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
   omcd_chk omcd_chk_inst (.sys_clk(sys_clk), .rst_b(rst_b), .tx_off(lnk.tx_off), .fault(lnk.fault),
      .present(lnk.present), .scl(lnk.scl), .sda(lnk.sda), .sda_h_oe(lnk.sda_h_oe), .sda_d_oe(lnk.sda_d_oe),
      .rx_light_absent(lnk.rx_light_absent));
   always #50 sys_clk = ~sys_clk;
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic conclude();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      @(posedge sys_clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1 got = rdata;
      @(posedge sys_clk);
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string nm);
      notes.push_back('{nm, e, m, 2'h0});
      bus(1'b0, a, 32'h0);
   endtask
   // Sel 1 is laser enable, 2 is interrupt
   task automatic pin(input logic [1:0] sel, input logic e, input string nm);
      notes.push_back('{nm, {31'h0, e}, 32'h1, sel});
      pk <= 1'b1;
      @(posedge sys_clk);
      pk <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic cycle_off();
      wreg(omcd_pkg::REG_CTRL, 32'h1);
      repeat (4) @(posedge sys_clk);
      wreg(omcd_pkg::REG_CTRL, 32'h0);
      repeat (8) @(posedge sys_clk);
   endtask
   task automatic xfer(input logic sp, input logic w, input logic [7:0] p, input logic [7:0] d);
      int k;
      wreg(omcd_pkg::REG_CMD, {8'h00, d, 6'h00, w, sp, p});
      // Order while busy, must be ignored
      wreg(omcd_pkg::REG_CMD, {8'h00, ~d, 6'h00, w, sp, ~p});
      k = 0;
      got = 32'h1;
      while (got[0] === 1'b1 && k < 400) begin
         rreg(omcd_pkg::REG_STAT, 32'h0, 32'h0, "poll");
         k++;
      end
      if (k == 400) begin
         errors++;
      end
   endtask
   function automatic logic [7:0] diag_byte(input int i);
      logic [15:0] w;
      w = i < 2 ? temp : i < 4 ? vcc : i < 6 ? bias : i < 8 ? tx_pwr : rx_pwr;
      return i % 2 == 0 ? w[15:8] : w[7:0];
   endfunction
   // ----------------------------------------
   // Monitor and timeout
   // ----------------------------------------
   always @(posedge sys_clk) begin
      omcd_note_t n;
      rd_d <= rd;
      cyc <= cyc + 1;
      if (rd_d || pk) begin
         n = notes.pop_front();
         if (n.m != 32'h0) begin
            cmp(n.nm, n.e & n.m, (n.sel == 2'h0 ? rdata : {31'h0, n.sel == 2'h1 ? laser_en : irq}) & n.m);
         end
      end
      if (cyc == 20000) begin
         errors++;
         conclude();
      end
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      int i;
      int v;
      logic [7:0] p;
      logic [7:0] d;
      @(posedge sys_clk);
      temp <= 16'($random(seed));
      vcc <= 16'($random(seed));
      bias <= 16'($random(seed));
      tx_pwr <= 16'($random(seed));
      rx_pwr <= 16'(omcd_pkg::DARK_LEVEL + 16'h0100);
      repeat (15) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      rreg(omcd_pkg::REG_CTRL, 32'h1, 32'hffffffff, "ctrl");
      rreg(omcd_pkg::REG_EVT, 32'h0, 32'h3, "events");
      rreg(omcd_pkg::REG_STAT, 32'h0, 32'h14, "stat pins");
      wreg(8'h1c, $random(seed));
      rreg(8'h1c, 32'h0, 32'hffffffff, "unmapped");
      pin(2'h1, 1'b0, "laser_en");
      wreg(omcd_pkg::REG_CTRL, 32'h2);
      repeat (8) @(posedge sys_clk);
      pin(2'h1, 1'b0, "laser_en float");
      $display("test reset done");
      wreg(omcd_pkg::REG_EVT_CLR, 32'h7);
      wreg(omcd_pkg::REG_EVT_EN, 32'h7);
      rreg(omcd_pkg::REG_EVT_EN, 32'h7, 32'hffffffff, "event enable");
      wreg(omcd_pkg::REG_CTRL, 32'h0);
      repeat (8) @(posedge sys_clk);
      pin(2'h1, 1'b1, "laser_en");
      for (i = 0; i < 2; i++) begin
         if (i == 0) begin
            eye_trip <= 1'b1;
         end else begin
            op_cond_bad <= 1'b1;
         end
         repeat (8) @(posedge sys_clk);
         rreg(omcd_pkg::REG_STAT, 32'h4, 32'h4, "fault pin");
         rreg(omcd_pkg::REG_EVT, 32'h2, 32'h2, "fault event");
         pin(2'h1, 1'b0, "laser_en");
         pin(2'h2, 1'b1, "irq");
         wreg(omcd_pkg::REG_EVT_EN, 32'h0);
         pin(2'h2, 1'b0, "irq masked");
         wreg(omcd_pkg::REG_EVT_EN, 32'h7);
         cycle_off();
         rreg(omcd_pkg::REG_STAT, 32'h4, 32'h4, "fault back");
         eye_trip <= 1'b0;
         op_cond_bad <= 1'b0;
         cycle_off();
         rreg(omcd_pkg::REG_STAT, 32'h0, 32'h4, "fault cleared");
         pin(2'h1, 1'b1, "laser_en");
         wreg(omcd_pkg::REG_EVT_CLR, 32'h7);
         pin(2'h2, 1'b0, "irq cleared");
      end
      $display("test laser done");
      for (i = 0; i < 4; i++) begin
         v = i < 2 ? int'(omcd_pkg::DARK_LEVEL) - 1 + i : $random(seed);
         rx_pwr <= v[15:0];
         repeat (8) @(posedge sys_clk);
         rreg(omcd_pkg::REG_STAT, {28'h0, v[15:0] < omcd_pkg::DARK_LEVEL, 3'h0}, 32'h8, "light absent");
      end
      rreg(omcd_pkg::REG_EVT, 32'h4, 32'h4, "light event");
      $display("test light done");
      p = 8'($random(seed));
      d = 8'($random(seed));
      xfer(1'b0, 1'b1, p, d);
      rreg(omcd_pkg::REG_STAT, 32'h0, 32'h2, "id write ack");
      xfer(1'b0, 1'b0, p, 8'h00);
      rreg(omcd_pkg::REG_STAT, {16'h0, d, 8'h0}, 32'hff02, "id byte");
      xfer(1'b0, 1'b1, 8'hff, ~d);
      xfer(1'b0, 1'b0, 8'hff, 8'h00);
      rreg(omcd_pkg::REG_STAT, {16'h0, ~d, 8'h0}, 32'hff02, "id last byte");
      for (i = 0; i < 10; i++) begin
         xfer(1'b1, 1'b0, omcd_pkg::DIAG_BASE + i[7:0], 8'h00);
         rreg(omcd_pkg::REG_STAT, {16'h0, diag_byte(i), 8'h0}, 32'hff02, "diag byte");
      end
      xfer(1'b1, 1'b1, omcd_pkg::DIAG_BASE, ~temp[15:8]);
      xfer(1'b1, 1'b0, omcd_pkg::DIAG_BASE, 8'h00);
      rreg(omcd_pkg::REG_STAT, {16'h0, temp[15:8], 8'h0}, 32'hff02, "diag after write");
      xfer(1'b1, 1'b0, 8'h00, 8'h00);
      rreg(omcd_pkg::REG_STAT, 32'h0, 32'hff02, "diag unused");
      rreg(omcd_pkg::REG_EVT, 32'h1, 32'h1, "done event");
      $display("test link done");
      conclude();
   end
endmodule
